// ### common/phy_reg_map.vh
`ifndef PHY_REG_MAP_VH
`define PHY_REG_MAP_VH

// ****
// Register addresses
// ****
`define ADDR_NODE_IDENTITY 4'h0
`define ADDR_ROOT_RESET_GAP 4'h1
`define ADDR_SPEED_PORTS 4'h2
`define ADDR_PORT1_STATE 4'h3
`define ADDR_PORT2_STATE 4'h4
`define ADDR_PORT3_STATE 4'h5
`define ADDR_EVENT_FLAGS 4'h6
`define ADDR_SILICON_REV 4'h7
`define ADDR_RESERVED_EIGHT 4'h8
`define ADDR_SPEED_SHORT_RST 4'h9
`define ADDR_ROUND_TRIP_HIGH 4'hA
`define ADDR_ROUND_TRIP_LOW 4'hB

// ****
// Field positions, bit 7 leftmost
// ****
`define BIT_ROOT_CLAIM 7
`define BIT_BUS_RESET_TRIGGER 6
`define BIT_LOOP_SUSPECTED 7
`define BIT_SUPPLY_DROP 6
`define BIT_FORCE_LOW_SPEED 1
`define BIT_ARB_RESET_REQUEST 0

// ****
// Fixed and reset values
// ****
`define TOP_SPEED_CODE 2'h1
`define SPEED_CODE_LOW 2'h0
`define PORT_COUNT_CODE 5'h03
`define GAP_COUNT_RESET 6'h00
`define SILICON_REVISION_DEFAULT 4'h1

// ****
// Control pair codes, device driving
// ****
`define CTL_IDLE 2'h0
`define CTL_STATUS 2'h1
`define CTL_RECEIVE 2'h2
`define CTL_GRANT 2'h3
// Link driving after a grant
`define CTL_LINK_RELEASE 2'h0
`define CTL_LINK_TRANSMIT 2'h2

// ****
// Request types and stop positions
// ****
`define REQ_TYPE_READ 3'h4
`define REQ_TYPE_WRITE 3'h5
`define REQ_STOP_BUS 5'd5
`define REQ_STOP_READ 5'd7
`define REQ_STOP_WRITE 5'd15

// ****
// Timing
// ****
`define STATUS_SYMBOLS 3'd6

`endif

// ### tb/link_controller_model.sv
`timescale 1ns/10ps
`include "phy_reg_map.vh"
module link_controller_model (
   // System
   input wire clock,
   // Device drive state
   input wire controlOe,
   // Toward the device
   output reg requestLine,
   output wire [1:0] ctlOut,
   output wire [1:0] dataOut
);
   reg own = 1'h0;
   reg [1:0] ctl = 2'h0;
   reg [1:0] data = 2'h0;
   initial requestLine = 1'h0;
   // Released pair shows hold only
   assign ctlOut = own ? ctl : 2'h1;
   assign dataOut = own ? data : 2'h2;
   // ****
   // Requests
   // ****
   task shift(input [16:0] f, input integer n);
      integer i;
      for (i = n - 1; i >= 0; i = i - 1) begin
         requestLine = f[i];
         @(posedge clock);
         #1;
      end
      requestLine = 1'h0;
   endtask
   task rd(input [3:0] a);
      shift({8'h0, 1'h1, `REQ_TYPE_READ, a, 1'h0}, 9);
   endtask
   task wr(input [3:0] a, input [7:0] d);
      shift({1'h1, `REQ_TYPE_WRITE, a, d, 1'h0}, 17);
   endtask
   task req(input [2:0] t, input [1:0] s, input stopBit);
      shift({10'h0, 1'h1, t, s, stopBit}, 7);
   endtask
   // ****
   // Transmit after grant
   // ****
   task send_packet(input [1:0] d0, input [1:0] d1);
      integer k;
      k = 0;
      while (controlOe && k < 10) begin
         @(posedge clock);
         #1;
         k = k + 1;
      end
      own = 1'h1;
      ctl = 2'h1;
      @(posedge clock);
      #1;
      ctl = `CTL_LINK_TRANSMIT;
      data = d0;
      @(posedge clock);
      #1;
      data = d1;
      @(posedge clock);
      #1;
      ctl = `CTL_LINK_RELEASE;
      @(posedge clock);
      #1;
      own = 1'h0;
   endtask
endmodule // link_controller_model

// ### tb/phy_reg_props_properties.sv
`timescale 1ns/10ps
`include "phy_reg_map.vh"
module phy_reg_props (
   // System
   input wire clock,
   input wire rstn,
   // Link pairs
   input wire [1:0] linkControlIn,
   input wire [1:0] linkControlOut,
   input wire linkControlOe,
   input wire [1:0] linkDataIn,
   input wire [1:0] linkDataOut,
   input wire linkDataOe,
   // Core side
   input wire rxValid,
   input wire [1:0] rxData,
   input wire grantLink,
   input wire txValid,
   input wire [1:0] txData,
   input wire busResetDone,
   input wire busResetRequest,
   input wire shortResetRequest,
   input wire busRequestValid,
   input wire [1:0] busRequestSpeed,
   input wire lowSpeedOnly,
   input wire lowSpeedStrapPin
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // ****
   // Pair encoding
   // ****
   property p_rx_code;
      rxValid |=> linkControlOe && linkControlOut == `CTL_RECEIVE;
   endproperty
   a_rx_code: assert property (p_rx_code) else $error("receive code missing");
   property p_rx_data;
      rxValid |=> linkDataOut == $past(rxData);
   endproperty
   a_rx_data: assert property (p_rx_data) else $error("receive symbol wrong");
   property p_grant;
      grantLink && !rxValid |=> linkControlOut == `CTL_GRANT ##1 !linkControlOe;
   endproperty
   a_grant: assert property (p_grant) else $error("grant not given");
   property p_tx;
      !linkControlOe && linkControlIn == `CTL_LINK_TRANSMIT |=>
         txValid && txData == $past(linkDataIn);
   endproperty
   a_tx: assert property (p_tx) else $error("link symbol lost");
   property p_take_back;
      $rose(linkControlOe) |-> linkControlOut == `CTL_IDLE;
   endproperty
   a_take_back: assert property (p_take_back) else $error("pair not idle");
   property p_oe_pair;
      linkDataOe == linkControlOe;
   endproperty
   a_oe_pair: assert property (p_oe_pair) else $error("pair enables differ");
   // ****
   // Controls
   // ****
   property p_trig_clear;
      $fell(busResetRequest) |-> $past(busResetDone);
   endproperty
   a_trig_clear: assert property (p_trig_clear) else $error("trigger cleared early");
   property p_arb_clear;
      $fell(shortResetRequest) |-> $past(busResetDone);
   endproperty
   a_arb_clear: assert property (p_arb_clear) else $error("short reset cleared early");
   property p_slow;
      busRequestValid && (lowSpeedOnly || !lowSpeedStrapPin) |->
         busRequestSpeed == `SPEED_CODE_LOW;
   endproperty
   a_slow: assert property (p_slow) else $error("speed not limited");
endmodule // phy_reg_props

// ### tb/testbench.sv
`timescale 1ns/10ps
`include "phy_reg_map.vh"
module testbench;
   localparam [3:0] REV = 4'hA; // Arbitrary value
   localparam [23:0] PORT_EXP = 24'hC9956C;
   reg clock = 1'h0;
   reg rstn = 1'h0;
   reg [5:0] nodeNumber = 6'h2D;
   reg isRoot = 1'h1;
   reg cablePowerPresent = 1'h1;
   reg [5:0] pairALineState = 6'h39;
   reg [5:0] pairBLineState = 6'h06;
   reg [2:0] downstreamPortFlag = 3'h5;
   reg [2:0] attachedFlag = 3'h3;
   reg [2:0] portHighSpeedCapable = 3'h6;
   reg lowSpeedStrapPin = 1'h1;
   reg treeIdTimeout = 1'h0, busResetDone = 1'h0, configPacketSent = 1'h0;
   reg packetReceived = 1'h0, grantLink = 1'h0, rxValid = 1'h0;
   reg [1:0] rxData = 2'h0;
   wire linkRequestLine, linkControlOe, linkDataOe, rootClaim, busResetRequest;
   wire shortResetRequest, lowSpeedOnly, busRequestValid, txValid;
   wire [1:0] linkControlOut, linkDataOut, busRequestSpeed, txData, modelCtl, modelData;
   wire [2:0] busRequestType;
   wire [5:0] gapCount;
   wire [1:0] linkControlIn = linkControlOe ? linkControlOut : modelCtl;
   wire [1:0] linkDataIn = linkDataOe ? linkDataOut : modelData;
   integer n_errors = 0, check_count = 0, cycles = 0, i;
   reg [7:0] d, hi, lo, txCount = 8'h0;
   reg [1:0] lastTx;
   reg seen;
   serial_bus_phy_register_bank #(.SILICON_REVISION(REV)) serial_bus_phy_register_bank_i (
      .clock, .rstn, .linkRequestLine, .linkControlIn, .linkControlOut, .linkControlOe,
      .linkDataIn, .linkDataOut, .linkDataOe, .nodeNumber, .isRoot, .cablePowerPresent,
      .pairALineState, .pairBLineState, .downstreamPortFlag, .attachedFlag,
      .portHighSpeedCapable, .lowSpeedStrapPin, .treeIdTimeout, .busResetDone,
      .configPacketSent, .packetReceived, .grantLink, .rxValid, .rxData, .rootClaim,
      .busResetRequest, .shortResetRequest, .gapCount, .lowSpeedOnly, .busRequestValid,
      .busRequestType, .busRequestSpeed, .txValid, .txData);
   link_controller_model link_controller_model_i (.clock, .controlOe(linkControlOe),
      .requestLine(linkRequestLine), .ctlOut(modelCtl), .dataOut(modelData));
   always #10 clock = ~clock;
   always @(posedge clock) begin
      if (txValid) begin
         txCount <= txCount + 8'h1;
         lastTx <= txData;
      end
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         finish_test;
      end
   end
   // ****
   // Helpers
   // ****
   task check(input [15:0] s, input [15:0] e);
      check_count = check_count + 1;
      if (s !== e) begin
         n_errors = n_errors + 1;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task rd(input [3:0] a, output [7:0] v);
      reg [11:0] w;
      integer k;
      link_controller_model_i.rd(a);
      k = 0;
      while (!(linkControlOe && linkControlOut === `CTL_STATUS) && k < 40) begin
         tick(1);
         k = k + 1;
      end
      for (k = 0; k < 6; k = k + 1) begin
         w = {w[9:0], linkDataOut};
         tick(1);
      end
      check(w[11:8], a);
      check(linkControlOut, `CTL_IDLE);
      v = w[7:0];
   endtask
   task rdc(input [3:0] a, input [7:0] e);
      rd(a, d);
      check(d, e);
   endtask
   task breq(input [2:0] t, input [1:0] s, input [1:0] es);
      integer k;
      link_controller_model_i.req(t, s, 1'h0);
      k = 0;
      while (busRequestValid !== 1'h1 && k < 10) begin
         tick(1);
         k = k + 1;
      end
      check({busRequestValid, busRequestType, busRequestSpeed}, {1'h1, t, es});
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   task t_regs;
      rdc(4'h0, 8'hB7);
      rdc(4'h1, 8'h00);
      rdc(4'h2, 8'h43);
      for (i = 0; i < 3; i = i + 1)
         rdc(i[3:0] + 4'h3, PORT_EXP[8*i +: 8]);
      rdc(4'h6, 8'h20);
      rd(4'h7, d);
      check(d[3:0], REV);
      rdc(4'h9, 8'h00);
      $display("done registers");
   endtask
   task t_write;
      link_controller_model_i.wr(4'h1, 8'hBF);
      tick(2);
      check({rootClaim, gapCount}, 7'h7F);
      rdc(4'h1, 8'hBF);
      link_controller_model_i.wr(4'h1, 8'h45);
      tick(7);
      check({rootClaim, busResetRequest}, 2'h1);
      busResetDone = 1'h1;
      tick(1);
      busResetDone = 1'h0;
      tick(1);
      check(busResetRequest, 1'h0);
      rdc(4'h1, 8'h05);
      rdc(4'h6, 8'h30);
      $display("done writes");
   endtask
   task t_low;
      link_controller_model_i.wr(4'h9, 8'h03);
      tick(2);
      check({shortResetRequest, lowSpeedOnly}, 2'h3);
      breq(3'h3, 2'h1, 2'h0);
      busResetDone = 1'h1;
      tick(1);
      busResetDone = 1'h0;
      lowSpeedStrapPin = 1'h0;
      rdc(4'h9, 8'h06);
      link_controller_model_i.wr(4'h9, 8'h00);
      breq(3'h2, 2'h1, 2'h0);
      lowSpeedStrapPin = 1'h1;
      breq(3'h0, 2'h1, 2'h1);
      link_controller_model_i.req(3'h6, 2'h1, 1'h0);
      seen = 1'h0;
      repeat (10) begin
         tick(1);
         seen = seen | busRequestValid;
      end
      check(seen, 1'h0);
      $display("done speed");
   endtask
   task t_events;
      treeIdTimeout = 1'h1;
      cablePowerPresent = 1'h0;
      tick(1);
      treeIdTimeout = 1'h0;
      link_controller_model_i.req(3'h3, 2'h0, 1'h1);
      tick(2);
      rdc(4'h6, 8'hD8);
      rdc(4'h6, 8'hD0);
      rdc(4'h0, 8'hB6);
      link_controller_model_i.wr(4'h6, 8'h00);
      cablePowerPresent = 1'h1;
      rdc(4'h6, 8'h30);
      configPacketSent = 1'h1;
      tick(1);
      configPacketSent = 1'h0;
      tick(299);
      packetReceived = 1'h1;
      tick(1);
      packetReceived = 1'h0;
      rd(4'hA, hi);
      rd(4'hB, lo);
      check({hi, lo}, 16'h012B);
      rdc(4'hA, hi);
      $display("done events");
   endtask
   task t_pair;
      rxValid = 1'h1;
      rxData = 2'h2;
      tick(1);
      check({linkControlOut, linkDataOut}, 4'hA);
      rxValid = 1'h0;
      tick(1);
      check(linkControlOut, `CTL_IDLE);
      grantLink = 1'h1;
      tick(1);
      grantLink = 1'h0;
      check(linkControlOut, `CTL_GRANT);
      link_controller_model_i.send_packet(2'h2, 2'h1);
      tick(3);
      check({txCount, lastTx, linkControlOe, linkControlOut}, 13'h004C);
      $display("done pair");
   endtask
   initial begin
      repeat (3) @(posedge clock);
      #1;
      rstn = 1'h1;
      t_regs;
      t_write;
      t_low;
      t_events;
      t_pair;
      finish_test;
   end
endmodule // testbench
bind serial_bus_phy_register_bank phy_reg_props phy_reg_props_i (
   .clock, .rstn, .linkControlIn, .linkControlOut, .linkControlOe, .linkDataIn,
   .linkDataOut, .linkDataOe, .rxValid, .rxData, .grantLink, .txValid, .txData,
   .busResetDone, .busResetRequest, .shortResetRequest, .busRequestValid,
   .busRequestSpeed, .lowSpeedOnly, .lowSpeedStrapPin);

// ### verilog/link_request_receiver.v
`timescale 1ns/10ps
`include "phy_reg_map.vh"

module link_request_receiver (
   // System
   input wire clock,
   input wire rstn,
   // Serial request line
   input wire requestLine,
   // Decoded request
   output reg reqValid,
   output reg [2:0] reqType,
   output reg [1:0] reqSpeed,
   output reg [3:0] reqAddr,
   output reg [7:0] reqData,
   output reg reqBad
);
   localparam IDLE = 1'b0;
   localparam COLLECT = 1'b1;

   reg state_r;
   reg [4:0] bitCnt_r;
   reg [14:0] shift_r;
   reg [2:0] type_r;
   wire [2:0] typeNow;
   reg [4:0] stopIdx;

   assign typeNow = (bitCnt_r == 5'd3) ? shift_r[2:0] : type_r;

   always @* begin
      case (typeNow)
         `REQ_TYPE_READ: stopIdx = `REQ_STOP_READ;
         `REQ_TYPE_WRITE: stopIdx = `REQ_STOP_WRITE;
         default: stopIdx = `REQ_STOP_BUS;
      endcase
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= IDLE;
         bitCnt_r <= 5'h00;
         shift_r <= 15'h0000;
         type_r <= 3'h0;
         reqValid <= 1'b0;
         reqType <= 3'h0;
         reqSpeed <= 2'h0;
         reqAddr <= 4'h0;
         reqData <= 8'h00;
         reqBad <= 1'b0;
      end else begin
         reqValid <= 1'b0;
         reqBad <= 1'b0;
         case (state_r)
            IDLE: begin
               // A 1 on an idle line is the start bit [RULE25]
               if (requestLine) begin
                  state_r <= COLLECT;
                  bitCnt_r <= 5'h00;
               end
            end
            COLLECT: begin
               if (bitCnt_r == 5'd3)
                  type_r <= shift_r[2:0];
               if (bitCnt_r >= 5'd3 && bitCnt_r == stopIdx) begin
                  state_r <= IDLE;
                  reqType <= typeNow;
                  reqSpeed <= shift_r[1:0];
                  reqAddr <= (typeNow == `REQ_TYPE_WRITE) ? shift_r[11:8] : shift_r[3:0];
                  reqData <= shift_r[7:0];
                  // Missing stop bit marks the request malformed [RULE15]
                  if (requestLine)
                     reqBad <= 1'b1;
                  else
                     reqValid <= 1'b1;
               end else begin
                  shift_r <= {shift_r[13:0], requestLine};
                  bitCnt_r <= bitCnt_r + 5'd1;
               end
            end
            default: state_r <= IDLE;
         endcase
      end
   end
endmodule // link_request_receiver

// ### verilog/serial_bus_phy_register_bank.v
// Behaviour
// [RULE1] Read-only 6-bit node number from self-identification.
// [RULE2] Address 0 shows root status and cable power present.
// [RULE3] Root claim bit asks to become root at next bus reset.
// [RULE4] Bus reset trigger starts a reset and self-clears once it happened.
// [RULE5] Writable 6-bit gap count steers arbitration gap timing.
// [RULE6] Top speed code reads 01, meaning 200 Mbit/s.
// [RULE7] Port count reads fixed pattern 00011, three ports.
// [RULE8] Per port, two 2-bit line states per twisted pair; the code maps one 2-bit state for each of pair A and pair B.
// [RULE9] Per port, downstream flag: 1 child, 0 parent.
// [RULE10] Per port, attached flag set when active cable connected.
// [RULE11] Per port, high-speed capable bit reads 1 for 200 Mbit/s.
// [RULE12] Loop suspected flag set when tree identification times out.
// [RULE13] Supply drop flag set on cable power fall; mirror repeats power.
// [RULE14] Reset originator flag set when this node began the last reset.
// [RULE15] Bad request flag set on malformed serial request.
// [RULE16] 4-bit silicon revision in low half of address 7.
// [RULE17] Address 9 shows whether low-speed strap pin is held low.
// [RULE18] Force low speed bit makes node 100 Mbit/s only; resets 0.
// [RULE19] Arbitrated reset request starts short reset, self-clears after it.
// [RULE20] 16-bit round trip counter from config packet sent to first receive.
// [RULE21] Link reads, writes, requests via serial line; device forwards receives.
// [RULE22] Data path to the link is always 2 bits wide.
// [RULE23] Device control codes: idle, status, receive, grant.
// [RULE24] After grant link drives release, hold or transmit.
// [RULE25] Serial requests start with 1, end with 0 stop bit.
// [RULE26] Type 100 reads with status answer, 101 writes, 110/111 ignored.
// [RULE27] Reset clears writable controls and event flags.
`timescale 1ns/10ps
`include "phy_reg_map.vh"

module serial_bus_phy_register_bank #(
   parameter [3:0] SILICON_REVISION = `SILICON_REVISION_DEFAULT, // Arbitrary value
   parameter NUM_PORTS = 3
) (
   // System
   input wire clock,
   input wire rstn,
   // Link request line
   input wire linkRequestLine,
   // Link control pair
   input wire [1:0] linkControlIn,
   output reg [1:0] linkControlOut,
   output reg linkControlOe,
   // Link data pair
   input wire [1:0] linkDataIn,
   output reg [1:0] linkDataOut,
   output reg linkDataOe,
   // Node state from the core
   input wire [5:0] nodeNumber,
   input wire isRoot,
   input wire cablePowerPresent,
   input wire [2*NUM_PORTS-1:0] pairALineState,
   input wire [2*NUM_PORTS-1:0] pairBLineState,
   input wire [NUM_PORTS-1:0] downstreamPortFlag,
   input wire [NUM_PORTS-1:0] attachedFlag,
   input wire [NUM_PORTS-1:0] portHighSpeedCapable,
   input wire lowSpeedStrapPin,
   // Core events, one-cycle pulses
   input wire treeIdTimeout,
   input wire busResetDone,
   input wire configPacketSent,
   input wire packetReceived,
   input wire grantLink,
   // Cable receive stream
   input wire rxValid,
   input wire [1:0] rxData,
   // Controls toward the core
   output wire rootClaim,
   output wire busResetRequest,
   output wire shortResetRequest,
   output wire [5:0] gapCount,
   output wire lowSpeedOnly,
   output reg busRequestValid,
   output reg [2:0] busRequestType,
   output reg [1:0] busRequestSpeed,
   // Link transmit stream toward the core
   output reg txValid,
   output reg [1:0] txData
);
   // ****
   // Request decode
   // ****
   wire reqValid;
   wire [2:0] reqType;
   wire [1:0] reqSpeed;
   wire [3:0] reqAddr;
   wire [7:0] reqData;
   wire reqBad;

   link_request_receiver requestRx (
      .clock(clock),
      .rstn(rstn),
      .requestLine(linkRequestLine),
      .reqValid(reqValid),
      .reqType(reqType),
      .reqSpeed(reqSpeed),
      .reqAddr(reqAddr),
      .reqData(reqData),
      .reqBad(reqBad)
   );

   wire isWrite = reqValid && (reqType == `REQ_TYPE_WRITE); // [RULE26]
   wire isRead = reqValid && (reqType == `REQ_TYPE_READ); // [RULE26]
   wire isBusReq = reqValid && !reqType[2]; // [RULE21]
   wire wrRootGap = isWrite && (reqAddr == `ADDR_ROOT_RESET_GAP);
   wire wrEvents = isWrite && (reqAddr == `ADDR_EVENT_FLAGS);
   wire wrSpeedRst = isWrite && (reqAddr == `ADDR_SPEED_SHORT_RST);

   // ****
   // Writable controls
   // ****
   reg rootClaim_r;
   reg busResetTrigger_r;
   reg [5:0] gapCount_r;
   reg forceLowSpeed_r;
   reg arbResetRequest_r;
   reg originator_r;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rootClaim_r <= 1'b0; // [RULE27]
         busResetTrigger_r <= 1'b0;
         gapCount_r <= `GAP_COUNT_RESET;
         forceLowSpeed_r <= 1'b0; // [RULE18]
         arbResetRequest_r <= 1'b0;
         originator_r <= 1'b0;
      end else begin
         if (wrRootGap) begin
            rootClaim_r <= reqData[`BIT_ROOT_CLAIM]; // [RULE3]
            gapCount_r <= reqData[5:0]; // [RULE5]
         end
         // A write of 1 beats the clear
         if (wrRootGap && reqData[`BIT_BUS_RESET_TRIGGER])
            busResetTrigger_r <= 1'b1; // [RULE4]
         else if (busResetDone)
            busResetTrigger_r <= 1'b0; // [RULE4]
         else if (wrRootGap)
            busResetTrigger_r <= 1'b0;
         if (wrSpeedRst)
            forceLowSpeed_r <= reqData[`BIT_FORCE_LOW_SPEED]; // [RULE18]
         if (wrSpeedRst && reqData[`BIT_ARB_RESET_REQUEST])
            arbResetRequest_r <= 1'b1; // [RULE19]
         else if (busResetDone)
            arbResetRequest_r <= 1'b0; // [RULE19]
         else if (wrSpeedRst)
            arbResetRequest_r <= 1'b0;
         // Several nodes may claim the last reset
         if (busResetDone)
            originator_r <= busResetTrigger_r | arbResetRequest_r; // [RULE14]
      end
   end

   assign rootClaim = rootClaim_r; // [RULE3]
   assign busResetRequest = busResetTrigger_r; // [RULE4]
   assign shortResetRequest = arbResetRequest_r; // [RULE19]
   assign gapCount = gapCount_r; // [RULE5]
   assign lowSpeedOnly = forceLowSpeed_r; // [RULE18]

   // ****
   // Event flags
   // ****
   reg loopFlag_r;
   reg supplyDrop_r;
   reg badRequest_r;
   reg powerPrev_r;
   reg strapLow_r;
   reg pendRead_r;
   reg [3:0] pendAddr_r;
   reg linkOwns_r;
   wire statusBusy;
   wire powerFell = powerPrev_r && !cablePowerPresent;
   wire pairTaken = linkOwns_r || rxValid || grantLink;
   wire statusLoad = pendRead_r && !statusBusy && !pairTaken;
   // Cleared on loading the answer, which still shows it
   wire rdEvents = statusLoad && (pendAddr_r == `ADDR_EVENT_FLAGS);

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         loopFlag_r <= 1'b0; // [RULE27]
         supplyDrop_r <= 1'b0;
         badRequest_r <= 1'b0;
         powerPrev_r <= 1'b0;
         strapLow_r <= 1'b0;
      end else begin
         powerPrev_r <= cablePowerPresent;
         strapLow_r <= !lowSpeedStrapPin; // [RULE17]
         // Hardware set beats a same-cycle write
         if (treeIdTimeout)
            loopFlag_r <= 1'b1; // [RULE12]
         else if (wrEvents)
            loopFlag_r <= reqData[`BIT_LOOP_SUSPECTED];
         if (powerFell)
            supplyDrop_r <= 1'b1; // [RULE13]
         else if (wrEvents)
            supplyDrop_r <= reqData[`BIT_SUPPLY_DROP];
         if (reqBad)
            badRequest_r <= 1'b1; // [RULE15]
         else if (rdEvents)
            badRequest_r <= 1'b0;
      end
   end

   // ****
   // Round trip counter
   // ****
   reg [15:0] roundTrip_r;
   reg counting_r;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         roundTrip_r <= 16'h0000;
         counting_r <= 1'b0;
      end else if (configPacketSent) begin
         roundTrip_r <= 16'h0000; // [RULE20]
         counting_r <= 1'b1;
      end else if (counting_r) begin
         // Held until the next configuration packet
         if (packetReceived)
            counting_r <= 1'b0; // [RULE20]
         else if (roundTrip_r != 16'hFFFF)
            roundTrip_r <= roundTrip_r + 16'h0001; // [RULE20]
      end
   end

   // ****
   // Register read map
   // ****
   wire [8*NUM_PORTS-1:0] portBytes;
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p = p + 1) begin : portMap
         assign portBytes[8*p +: 8] = {pairALineState[2*p +: 2], // [RULE8]
            pairBLineState[2*p +: 2], // [RULE8]
            downstreamPortFlag[p], // [RULE9]
            attachedFlag[p], // [RULE10]
            1'b0,
            portHighSpeedCapable[p]}; // [RULE11]
      end
   endgenerate

   function [7:0] readReg;
      input [3:0] addr;
      begin
         case (addr)
            `ADDR_NODE_IDENTITY: readReg = {nodeNumber, isRoot, cablePowerPresent}; // [RULE1] [RULE2]
            `ADDR_ROOT_RESET_GAP: readReg = {rootClaim_r, busResetTrigger_r, gapCount_r};
            `ADDR_SPEED_PORTS: readReg = {`TOP_SPEED_CODE, 1'b0, `PORT_COUNT_CODE}; // [RULE6] [RULE7]
            `ADDR_PORT1_STATE: readReg = portBytes[7:0];
            `ADDR_PORT2_STATE: readReg = portBytes[15:8];
            `ADDR_PORT3_STATE: readReg = portBytes[23:16];
            `ADDR_EVENT_FLAGS: readReg = {loopFlag_r, supplyDrop_r, cablePowerPresent, // [RULE13]
               originator_r, badRequest_r, 3'h0}; // [RULE14] [RULE15]
            `ADDR_SILICON_REV: readReg = {4'h0, SILICON_REVISION}; // [RULE16]
            `ADDR_SPEED_SHORT_RST: readReg = {5'h00, strapLow_r, // [RULE17]
               forceLowSpeed_r, arbResetRequest_r};
            `ADDR_ROUND_TRIP_HIGH: readReg = roundTrip_r[15:8]; // [RULE20]
            `ADDR_ROUND_TRIP_LOW: readReg = roundTrip_r[7:0]; // [RULE20]
            default: readReg = 8'h00;
         endcase
      end
   endfunction

   // ****
   // Bus requests toward the core
   // ****
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         busRequestValid <= 1'b0;
         busRequestType <= 3'h0;
         busRequestSpeed <= 2'h0;
      end else begin
         busRequestValid <= isBusReq; // [RULE21]
         if (isBusReq) begin
            busRequestType <= reqType;
            // Low speed mode or strap caps the speed
            busRequestSpeed <= (forceLowSpeed_r || strapLow_r) ? `SPEED_CODE_LOW : reqSpeed; // [RULE18]
         end
      end
   end

   // ****
   // Status answer to reads
   // ****
   // One read waits while the pair is taken; a newer read replaces it
   wire [1:0] statusPair;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pendRead_r <= 1'b0;
         pendAddr_r <= 4'h0;
      end else if (isRead) begin
         pendRead_r <= 1'b1; // [RULE26]
         pendAddr_r <= reqAddr;
      end else if (statusLoad) begin
         pendRead_r <= 1'b0;
      end
   end

   status_shift_out statusTx (
      .clock(clock),
      .rstn(rstn),
      .load(statusLoad),
      .word({pendAddr_r, readReg(pendAddr_r)}),
      .hold(pairTaken),
      .busy(statusBusy),
      .pairOut(statusPair)
   );

   // ****
   // Control and data pair drive
   // ****
   reg [1:0] ctlNxt;
   reg [1:0] dataNxt;
   reg driveNxt;

   always @* begin
      ctlNxt = `CTL_IDLE;
      dataNxt = 2'h0;
      driveNxt = 1'b1;
      if (linkOwns_r) begin
         driveNxt = 1'b0; // [RULE24]
      end else if (rxValid) begin
         ctlNxt = `CTL_RECEIVE; // [RULE23]
         dataNxt = rxData; // [RULE21] [RULE22]
      end else if (grantLink) begin
         ctlNxt = `CTL_GRANT; // [RULE23]
      end else if (statusBusy) begin
         ctlNxt = `CTL_STATUS; // [RULE23]
         dataNxt = statusPair; // [RULE22]
      end
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         linkControlOut <= `CTL_IDLE;
         linkControlOe <= 1'b0;
         linkDataOut <= 2'h0;
         linkDataOe <= 1'b0;
         linkOwns_r <= 1'b0;
         txValid <= 1'b0;
         txData <= 2'h0;
      end else begin
         linkControlOut <= ctlNxt;
         linkControlOe <= driveNxt;
         linkDataOut <= dataNxt;
         linkDataOe <= driveNxt;
         // Link owns the pair until it drives release
         if (!linkOwns_r && !rxValid && grantLink)
            linkOwns_r <= 1'b1; // [RULE24]
         else if (linkOwns_r && linkControlOe == 1'b0 && linkControlIn == `CTL_LINK_RELEASE)
            linkOwns_r <= 1'b0; // [RULE24]
         txValid <= linkOwns_r && !linkControlOe && (linkControlIn == `CTL_LINK_TRANSMIT);
         txData <= linkDataIn; // [RULE22]
      end
   end
endmodule // serial_bus_phy_register_bank

// ### verilog/status_shift_out.v
`timescale 1ns/10ps
`include "phy_reg_map.vh"

module status_shift_out (
   // System
   input wire clock,
   input wire rstn,
   // Load side
   input wire load,
   input wire [11:0] word,
   // Stall while the pair is taken
   input wire hold,
   // Symbol side
   output wire busy,
   output wire [1:0] pairOut
);
   reg [11:0] shift_r;
   reg [2:0] left_r;

   assign busy = (left_r != 3'd0);
   assign pairOut = shift_r[11:10];

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         shift_r <= 12'h000;
         left_r <= 3'd0;
      end else if (load && !busy) begin
         shift_r <= word;
         left_r <= `STATUS_SYMBOLS;
      end else if (busy && !hold) begin
         // Two bits per clock on the data pair [RULE22]
         shift_r <= {shift_r[9:0], 2'h0};
         left_r <= left_r - 3'd1;
      end
   end
endmodule // status_shift_out
